// ### rtl/fpe_pkg.sv
package fpe_pkg;
    // Register word offsets (byte addresses, one aligned word each)
    localparam logic [3:0] FPE_OFF_MODE = 4'h0;
    localparam logic [3:0] FPE_OFF_ERR = 4'h4;
    localparam logic [3:0] FPE_OFF_EBS = 4'h8;
    localparam logic [3:0] FPE_OFF_EBL = 4'hC;
    localparam logic [4:0] FPE_OFF_IST = 5'h10;
    localparam logic [4:0] FPE_OFF_IMSK = 5'h14;
    localparam logic [4:0] FPE_OFF_REGION = 5'h18;
    // Mode control field positions
    localparam int FPE_B_HWE = 7;
    localparam int FPE_B_SWE = 6;
    localparam int FPE_B_ESU = 5;
    localparam int FPE_B_PSU = 4;
    localparam int FPE_B_EV = 3;
    localparam int FPE_B_PV = 2;
    localparam int FPE_B_EGO = 1;
    localparam int FPE_B_WGO = 0;
    // Error status flag position
    localparam int FPE_B_ERR = 7;
    // Large-block register width in use
    localparam int FPE_EBL_USED = 4;
    // Interrupt status bit positions
    localparam int FPE_I_ERR = 0;
    localparam int FPE_I_SELCLR = 1;
    // Reset values
    localparam logic [7:0] FPE_RST_REG = 8'h00;
    // Erase block base addresses, large blocks
    localparam logic [17:0] FPE_BASE_EB8 = 18'h08000;
    localparam logic [17:0] FPE_BASE_EB9 = 18'h10000;
    localparam logic [17:0] FPE_BASE_BLOCK_SELECT_10 = 18'h20000;
    localparam logic [17:0] FPE_BASE_BLOCK_SELECT_11 = 18'h30000;
    // Small block size (4 KB step)
    localparam logic [17:0] FPE_SMALL_STEP = 18'h01000;
    // Flash operating state
    typedef enum logic [2:0] {
        FPE_IDLE = 3'b000,
        FPE_ESETUP = 3'b001,
        FPE_PSETUP = 3'b010,
        FPE_ERASE = 3'b011,
        FPE_PROG = 3'b100,
        FPE_EVERIFY = 3'b101,
        FPE_PVERIFY = 3'b110
    } fpe_state_t;
endpackage

// ### rtl/fpe_region.sv
`timescale 1ns/1ps
`default_nettype none
// Translates the one-hot block selection into a base address
module fpe_region (
    // Selection
    input wire logic [7:0] small_sel,
    input wire logic [3:0] large_sel,
    // Decoded region
    output logic [17:0] base,
    output logic valid
);
    import fpe_pkg::*;

    logic [17:0] small_base;
    logic small_hit;

    // Small block n starts at n times 4 KB
    always_comb begin
        small_base = 18'h00000;
        small_hit = 1'b0;
        for (int n = 0; n < 8; n++) begin
            if (small_sel[n]) begin
                small_base = 18'(FPE_SMALL_STEP * n);
                small_hit = 1'b1;
            end
        end
    end

    // Large blocks override; selection is one-hot anyway
    always_comb begin
        base = small_base;
        valid = small_hit;
        if (large_sel[3]) begin
            base = FPE_BASE_BLOCK_SELECT_11;
            valid = 1'b1;
        end else if (large_sel[2]) begin
            base = FPE_BASE_BLOCK_SELECT_10;
            valid = 1'b1;
        end else if (large_sel[1]) begin
            base = FPE_BASE_EB9;
            valid = 1'b1;
        end else if (large_sel[0]) begin
            base = FPE_BASE_EB8;
            valid = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### rtl/fpe_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - hw enable flag is inverse of protect pin
// - sw enable set with hw enable enables
// - sw enable clear blocks other sets
// - erase setup bit enters erase setup
// - program setup bit enters program setup
// - erase verify bit enters erase verify
// - program verify bit enters program verify
// - erase go needs both enables, setup
// - program go needs both enables, setup
// - error flag set on error event during program or erase
// - reserved bits read zero
// - protect pin high clears block selects
// - sw enable low clears block selects
// - multiple selects clear all selects
// - bits 3,2 select top 64K blocks
// - bits 1,0 select 64K and 32K
// - protect pin guards program and erase
module fpe_ctrl (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RSTN,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [4:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Flash side
    input wire logic FLASH_PROTECT_PIN,
    input wire logic FLASH_ERROR_EVENT,
    output logic [2:0] FLASH_STATE,
    output logic [7:0] ERASE_SEL_SMALL,
    output logic [3:0] ERASE_SEL_LARGE,
    // Interrupt
    output logic IRQ
);
    import fpe_pkg::*;

    // Pin synchronisers
    logic prot_m_q, prot_q;
    logic err_m_q, err_q, err_prev_q;
    // Registers; mode bits 6:0 sit at their register positions
    logic [6:0] mode_q;
    logic err_flag_q;
    logic [7:0] ebs_q;
    logic [3:0] ebl_q;
    logic [1:0] ist_q, imsk_q;
    logic ack_q;
    logic [31:0] dat_q;
    // Registered state shown on the pins
    logic [2:0] state_out_q;
    logic [7:0] sel_small_q;
    logic [3:0] sel_large_q;
    logic irq_q;

    // Synchronise the protect pin and error event
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            prot_m_q <= 1'b1;
            prot_q <= 1'b1;
            err_m_q <= 1'b0;
            err_q <= 1'b0;
            err_prev_q <= 1'b0;
        end else begin
            prot_m_q <= FLASH_PROTECT_PIN;
            prot_q <= prot_m_q;
            err_m_q <= FLASH_ERROR_EVENT;
            err_q <= err_m_q;
            err_prev_q <= err_q;
        end
    end

    // Bus decode; a request is answered one edge after it is seen
    wire req = WB_CYC_I && WB_STB_I && !ack_q;
    // Writes land on the edge at which the master samples ack high
    wire commit = WB_CYC_I && WB_STB_I && ack_q;
    wire wr = commit && WB_WE_I && WB_SEL_I[0];
    wire wr_mode = wr && (WB_ADR_I[3:0] == FPE_OFF_MODE) && !WB_ADR_I[4];
    wire wr_ebs = wr && (WB_ADR_I[3:0] == FPE_OFF_EBS) && !WB_ADR_I[4];
    wire wr_ebl = wr && (WB_ADR_I[3:0] == FPE_OFF_EBL) && !WB_ADR_I[4];
    wire wr_ist = wr && (WB_ADR_I == FPE_OFF_IST);
    wire wr_imsk = wr && (WB_ADR_I == FPE_OFF_IMSK);
    wire [7:0] wdat = WB_DAT_I[7:0];

    wire hwe = !prot_q;
    wire swe_next = wr_mode ? (wdat[FPE_B_SWE] && hwe) : (mode_q[FPE_B_SWE] && hwe);
    wire both_en = hwe && mode_q[FPE_B_SWE];
    // other bits settable only under both enables
    wire low_ok = both_en && swe_next;
    wire [6:0] mode_wr_val = low_ok ? {swe_next, wdat[5:0]} : {swe_next, 6'h00};
    wire ego_ok = wdat[FPE_B_ESU] && wdat[FPE_B_EGO];
    wire wgo_ok = wdat[FPE_B_PSU] && wdat[FPE_B_WGO];
    // Go bits survive only with their setup bit in the same write
    wire [6:0] mode_wr_fin = {mode_wr_val[6:2], mode_wr_val[1] && ego_ok,
        mode_wr_val[0] && wgo_ok};
    // Protect pin high wipes every mode bit
    wire [6:0] mode_d = wr_mode ? mode_wr_fin :
        (hwe ? mode_q : 7'h00);

    // Block selects: new candidate values
    wire [7:0] ebs_cand = (wr_ebs && both_en) ? wdat : ebs_q;
    wire [3:0] ebl_cand = (wr_ebl && both_en) ? wdat[3:0] : ebl_q;
    wire [11:0] sel_all = {ebl_cand, ebs_cand};
    wire multi = (sel_all & (sel_all - 12'h001)) != 12'h000;
    wire sel_clear = prot_q || !mode_d[FPE_B_SWE] || multi;

    // Mode control register
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            mode_q <= 7'h00;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Erase block select registers
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ebs_q <= FPE_RST_REG;
            ebl_q <= 4'h0;
        end else if (sel_clear) begin
            // clear on protect, sw disable or multi
            ebs_q <= FPE_RST_REG;
            ebl_q <= 4'h0;
        end else begin
            ebs_q <= ebs_cand;
            ebl_q <= ebl_cand;
        end
    end

    // Error event edge while programming or erasing
    wire busy = mode_q[FPE_B_EGO] || mode_q[FPE_B_WGO];
    wire err_evt = err_q && !err_prev_q && busy;

    // Error flag, sticky until reset
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            err_flag_q <= 1'b0;
        end else if (err_evt) begin
            err_flag_q <= 1'b1;
        end
    end

    // Interrupt events
    wire [1:0] ist_set = {multi && !prot_q && mode_d[FPE_B_SWE], err_evt};
    wire [1:0] ist_d = ist_set | (ist_q & ~(wr_ist ? wdat[1:0] : 2'b00));

    // Interrupt status and mask, set wins over clear
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ist_q <= 2'b00;
            imsk_q <= 2'b00;
        end else begin
            ist_q <= ist_d;
            if (wr_imsk) begin
                imsk_q <= wdat[1:0];
            end
        end
    end

    // Flash operating state from mode bits
    fpe_state_t state_d;
    always_comb begin
        state_d = FPE_IDLE;
        if (!both_en) begin
            state_d = FPE_IDLE;
        end else if (mode_q[FPE_B_EGO]) begin
            state_d = FPE_ERASE;
        end else if (mode_q[FPE_B_WGO]) begin
            state_d = FPE_PROG;
        end else if (mode_q[FPE_B_ESU]) begin
            state_d = FPE_ESETUP;
        end else if (mode_q[FPE_B_PSU]) begin
            state_d = FPE_PSETUP;
        end else if (mode_q[FPE_B_EV]) begin
            state_d = FPE_EVERIFY;
        end else if (mode_q[FPE_B_PV]) begin
            state_d = FPE_PVERIFY;
        end
    end

    // Region decode for the read-back register
    logic [17:0] reg_base;
    logic reg_valid;
    fpe_region u_region (
        .small_sel(ebs_q),
        .large_sel(ebl_q),
        .base(reg_base),
        .valid(reg_valid)
    );

    // Read mux
    // flag sits above the stored bits
    wire [7:0] mode_rd = {hwe, mode_q};
    logic [31:0] rd_d;
    always_comb begin
        rd_d = 32'h00000000;
        unique case (WB_ADR_I)
            {1'b0, FPE_OFF_MODE}: rd_d = {24'h000000, mode_rd};
            {1'b0, FPE_OFF_ERR}: rd_d = {24'h000000, err_flag_q, 7'h00};
            {1'b0, FPE_OFF_EBS}: rd_d = {24'h000000, ebs_q};
            {1'b0, FPE_OFF_EBL}: rd_d = {28'h0000000, ebl_q};
            FPE_OFF_IST: rd_d = {30'h00000000, ist_q};
            FPE_OFF_IMSK: rd_d = {30'h00000000, imsk_q};
            FPE_OFF_REGION: rd_d = {13'h0000, reg_valid, reg_base};
            default: rd_d = 32'h00000000;
        endcase
    end

    // Bus answer, one wait state
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= req;
            dat_q <= req ? rd_d : 32'h00000000;
        end
    end

    // Registered outputs
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            state_out_q <= 3'b000;
            sel_small_q <= 8'h00;
            sel_large_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            state_out_q <= state_d;
            sel_small_q <= ebs_q;
            sel_large_q <= ebl_q;
            irq_q <= |(ist_d & imsk_q);
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = dat_q;
    assign FLASH_STATE = state_out_q;
    assign ERASE_SEL_SMALL = sel_small_q;
    assign ERASE_SEL_LARGE = sel_large_q;
    assign IRQ = irq_q;

    // Flag follows the pin two edges late, once the synchroniser has filled
    a_hwe_follows_pin: assert property (@(posedge CLOCK) disable iff (!RSTN)
        $past(RSTN, 2) |-> (mode_rd[7] == !$past(FLASH_PROTECT_PIN, 2)))
        else $error("hw enable flag wrong");
    // Protect pin clears selects next cycle
    a_prot_clears_sel: assert property (@(posedge CLOCK) disable iff (!RSTN)
        prot_q |=> (ebs_q == 8'h00) && (ebl_q == 4'h0)) else $error("sel not cleared");
    // SW disable clears selects
    a_swe_clears_sel: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !mode_q[FPE_B_SWE] |-> (ebs_q == 8'h00) && (ebl_q == 4'h0))
        else $error("sel set without sw enable");
    // Never more than one select bit
    a_sel_onehot: assert property (@(posedge CLOCK) disable iff (!RSTN)
        $onehot0({ebl_q, ebs_q})) else $error("multiple block selects");
    // Erase go only with setup
    a_ego_needs_esu: assert property (@(posedge CLOCK) disable iff (!RSTN)
        mode_q[FPE_B_EGO] |-> mode_q[FPE_B_ESU]) else $error("erase without setup");
    // Program go only with setup
    a_wgo_needs_psu: assert property (@(posedge CLOCK) disable iff (!RSTN)
        mode_q[FPE_B_WGO] |-> mode_q[FPE_B_PSU]) else $error("program without setup");
    // Mode bits clear without sw enable
    a_mode_gated: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !mode_q[FPE_B_SWE] |-> mode_q[5:0] == 6'h00) else $error("mode bit set");
    // Error event sets flag within a cycle
    a_err_sets_flag: assert property (@(posedge CLOCK) disable iff (!RSTN)
        err_evt |=> err_flag_q) else $error("error flag not set");
    // Erase setup reaches the state output
    a_state_erase: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (both_en && mode_q[FPE_B_ESU] && !mode_q[FPE_B_EGO] && !mode_q[FPE_B_WGO])
        |=> FLASH_STATE == FPE_ESETUP) else $error("erase setup not shown");
    // Program setup reaches the state output
    a_state_psetup: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (both_en && mode_q[FPE_B_PSU] && !mode_q[FPE_B_ESU] && !mode_q[FPE_B_EGO]
        && !mode_q[FPE_B_WGO]) |=> FLASH_STATE == FPE_PSETUP)
        else $error("program setup not shown");
    // Erase go reaches the state output
    a_state_erase_go: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (both_en && mode_q[FPE_B_EGO]) |=> FLASH_STATE == FPE_ERASE)
        else $error("erase not shown");
    // Program go reaches the state output
    a_state_prog_go: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (both_en && mode_q[FPE_B_WGO] && !mode_q[FPE_B_EGO]) |=> FLASH_STATE == FPE_PROG)
        else $error("program not shown");
    // Erase verify without setup or go bits reaches the state output
    a_state_everify: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (both_en && mode_q[FPE_B_EV] && (mode_q[5:4] == 2'h0) && (mode_q[1:0] == 2'h0))
        |=> FLASH_STATE == FPE_EVERIFY) else $error("erase verify not shown");
    // Program verify alone reaches the state output
    a_state_pverify: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (both_en && mode_q[FPE_B_PV] && (mode_q[5:3] == 3'h0) && (mode_q[1:0] == 2'h0))
        |=> FLASH_STATE == FPE_PVERIFY) else $error("program verify not shown");
    // Without both enables the flash rests idle
    a_idle_locked: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !both_en |=> FLASH_STATE == FPE_IDLE)
        else $error("state left idle while locked");
    // Protect pin high empties the mode register
    a_mode_clr_prot: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !hwe |=> mode_q == 7'h00)
        else $error("mode kept while protected");
    // Software enable only rises while the hw flag is set
    a_swe_needs_hwe: assert property (@(posedge CLOCK) disable iff (!RSTN)
        $rose(mode_q[FPE_B_SWE]) |-> $past(hwe))
        else $error("sw enable set while protected");
    // Select writes refused without both enables
    a_sel_locked: assert property (@(posedge CLOCK) disable iff (!RSTN)
        !both_en |=> (ebs_q == 8'h00) && (ebl_q == 4'h0))
        else $error("select taken while locked");
    // Error flag only leaves through reset
    a_err_sticky: assert property (@(posedge CLOCK) disable iff (!RSTN)
        err_flag_q |=> err_flag_q)
        else $error("error flag dropped");
    // Unmasked pending event raises the interrupt
    a_irq_raised: assert property (@(posedge CLOCK) disable iff (!RSTN)
        (|(ist_q & imsk_q)) && !wr_ist |=> IRQ)
        else $error("interrupt not raised");
    // Reserved status bits answer zero
    a_err_reserved: assert property (@(posedge CLOCK) disable iff (!RSTN)
        WB_ACK_O && (WB_ADR_I == {1'b0, FPE_OFF_ERR}) |-> WB_DAT_O[6:0] == 7'h00)
        else $error("reserved status bits set");
    // Reserved large-select bits answer zero
    a_ebl_reserved: assert property (@(posedge CLOCK) disable iff (!RSTN)
        WB_ACK_O && (WB_ADR_I == {1'b0, FPE_OFF_EBL}) |-> WB_DAT_O[31:4] == 28'h0000000)
        else $error("reserved select bits set");
endmodule
`default_nettype wire

// ### sim/fpe_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module fpe_ctrl_test;
    import fpe_pkg::*;
    // Short register addresses on the bus width
    localparam logic [4:0] A_MODE = 5'(FPE_OFF_MODE);
    localparam logic [4:0] A_ERR = 5'(FPE_OFF_ERR);
    localparam logic [4:0] A_EBS = 5'(FPE_OFF_EBS);
    localparam logic [4:0] A_EBL = 5'(FPE_OFF_EBL);
    // Clock, reset and bus drive
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [3:0] be = 4'h0;
    logic [31:0] wdat = 32'h0;
    // Flash side pins
    logic prot = 1'b0;
    logic ferr = 1'b0;
    // Design outputs
    logic [31:0] rdat;
    logic ack;
    logic irq;
    logic [2:0] state;
    logic [7:0] sel_s;
    logic [3:0] sel_l;
    // Bookkeeping
    int fails = 0;
    int n_tests = 0;
    logic [31:0] rd;
    logic [7:0] s;
    logic [3:0] l;
    int k;
    int r;
    // Mode bits and the states they lead to
    logic [7:0] mbit [4] = '{8'h20, 8'h10, 8'h08, 8'h04};
    logic [2:0] mst [4] = '{3'h1, 3'h2, 3'h5, 3'h6};

    // Free-running 25 MHz clock
    always #20 clock = ~clock;

    fpe_ctrl fpe_ctrl_inst (
        .CLOCK(clock), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(be), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .FLASH_PROTECT_PIN(prot), .FLASH_ERROR_EVENT(ferr), .FLASH_STATE(state),
        .ERASE_SEL_SMALL(sel_s), .ERASE_SEL_LARGE(sel_l), .IRQ(irq)
    );

    // One classic Wishbone cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        be <= 4'hF;
        wdat <= {24'h0, d};
        // Wait for ack however long; the watchdog ends a hang
        do begin
            @(posedge clock);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // Value comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Register read comparison
    task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask

    // Let edges pass, then sample settled outputs
    task automatic wait_n(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic note(input string t);
        $display("test %s done, mismatches so far %0d", t, fails);
    endtask

    // Expected region word for a one-hot selection
    function automatic logic [31:0] region_of(input logic [7:0] sv, input logic [3:0] lv);
        logic [31:0] x;
        x = 32'h0;
        if ($countones({sv, lv}) == 1) x[18] = 1'b1;
        for (int b = 0; b < 8; b++) begin
            if (sv[b]) x[17:0] = 18'(b) << 12;
        end
        if (lv[0]) x[17:0] = 18'h08000;
        if (lv[1]) x[17:0] = 18'h10000;
        if (lv[2]) x[17:0] = 18'h20000;
        if (lv[3]) x[17:0] = 18'h30000;
        return x;
    endfunction

    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out;
    end

    // Main sequence
    initial begin
        void'($urandom(3316));
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        wait_n(4);
        // Reset values, reserved bits and an unmapped place
        rdchk(A_MODE, 32'h80);
        rdchk(A_ERR, 32'h0);
        rdchk(A_EBS, 32'h0);
        rdchk(A_EBL, 32'h0);
        rdchk(5'h1C, 32'h0);
        note("reset");
        // Nothing sets while software enable is clear
        bus(1'b1, A_MODE, 8'h3F);
        bus(1'b1, A_EBS, 8'h01);
        rdchk(A_MODE, 32'h80);
        rdchk(A_EBS, 32'h0);
        note("locked");
        // Each setup and verify bit alone, then cancelled
        for (k = 0; k < 4; k++) begin
            bus(1'b1, A_MODE, 8'h40);
            bus(1'b1, A_MODE, 8'h40 | mbit[k]);
            rdchk(A_MODE, {24'h0, 8'hC0 | mbit[k]});
            wait_n(1);
            chk(32'(state), 32'(mst[k]));
            bus(1'b1, A_MODE, 8'h40);
            wait_n(1);
            chk(32'(state), 32'h0);
        end
        note("modes");
        // Go bits refused without setup, taken with it
        bus(1'b1, A_MODE, 8'h42);
        rdchk(A_MODE, 32'hC0);
        bus(1'b1, A_MODE, 8'h41);
        rdchk(A_MODE, 32'hC0);
        bus(1'b1, A_MODE, 8'h60);
        bus(1'b1, A_MODE, 8'h62);
        wait_n(1);
        chk(32'(state), 32'h3);
        bus(1'b1, A_MODE, 8'h60);
        wait_n(1);
        chk(32'(state), 32'h1);
        bus(1'b1, A_MODE, 8'h40);
        bus(1'b1, A_MODE, 8'h50);
        bus(1'b1, A_MODE, 8'h51);
        wait_n(1);
        chk(32'(state), 32'h4);
        note("go");
        // Error while programming: masked, unmasked, cleared
        @(posedge clock);
        ferr <= 1'b1;
        wait_n(4);
        chk(32'(irq), 32'h0);
        rdchk(A_ERR, 32'h80);
        rdchk(FPE_OFF_IST, 32'h1);
        bus(1'b1, FPE_OFF_IMSK, 8'h01);
        wait_n(1);
        chk(32'(irq), 32'h1);
        bus(1'b1, FPE_OFF_IST, 8'h01);
        wait_n(1);
        chk(32'(irq), 32'h0);
        rdchk(A_ERR, 32'h80);
        ferr <= 1'b0;
        note("error");
        // Every block alone, then random ones
        bus(1'b1, A_MODE, 8'h40);
        for (k = 0; k < 18; k++) begin
            r = (k < 12) ? k : int'($urandom_range(11));
            s = 8'h0;
            l = 4'h0;
            if (r < 8) s[r] = 1'b1;
            else l[r - 8] = 1'b1;
            bus(1'b1, A_EBS, 8'h00);
            bus(1'b1, A_EBL, 8'h00);
            bus(1'b1, A_EBS, s);
            bus(1'b1, A_EBL, {4'h0, l});
            rdchk(A_EBS, {24'h0, s});
            rdchk(A_EBL, {28'h0, l});
            rdchk(FPE_OFF_REGION, region_of(s, l));
            chk({20'h0, sel_l, sel_s}, {20'h0, l, s});
        end
        note("blocks");
        // Two selects at once clear both registers; start from none
        bus(1'b1, A_EBS, 8'h00);
        bus(1'b1, A_EBL, 8'h00);
        bus(1'b1, A_EBS, 8'h01 << $urandom_range(7));
        bus(1'b1, A_EBL, 8'h01 << $urandom_range(3));
        rdchk(A_EBS, 32'h0);
        rdchk(A_EBL, 32'h0);
        rdchk(FPE_OFF_IST, 32'h2);
        note("multi");
        // Clearing software enable wipes the selection
        bus(1'b1, A_EBS, 8'h04);
        bus(1'b1, A_MODE, 8'h00);
        wait_n(1);
        chk(32'(sel_s), 32'h0);
        rdchk(A_EBS, 32'h0);
        rdchk(A_MODE, 32'h80);
        note("swoff");
        // Protect pin high locks everything out
        bus(1'b1, A_MODE, 8'h40);
        bus(1'b1, A_EBL, 8'h08);
        @(posedge clock);
        prot <= 1'b1;
        wait_n(4);
        chk(32'(sel_l), 32'h0);
        rdchk(A_MODE, 32'h0);
        bus(1'b1, A_MODE, 8'h40);
        rdchk(A_MODE, 32'h0);
        @(posedge clock);
        prot <= 1'b0;
        wait_n(4);
        rdchk(A_MODE, 32'h80);
        note("protect");
        close_out;
    end
endmodule
`default_nettype wire
